// >>> rtl/dclt_capture.v
/*
  Time-stamp capture for the second latch input and buffer-manager events.
  Two byte-wide read/write ports: network side and local host side.
  Assumes all inputs are synchronous to clk_sys_in and that each access
  strobe is a one-cycle pulse; read data appears one cycle after the strobe.
*/
`include "dclt_regs.vh"

module dclt_capture (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // Time bases and events
  input  wire [63:0] sys_time_in,        // System time
  input  wire [31:0] local_time_in,      // Local time
  input  wire        latch_b_in,         // Second latch input
  input  wire        frame_start_in,     // Pulse at start of each frame
  input  wire        net_event_in,       // Buffer manager raised network event
  input  wire        host_start_evt_in,  // Buffer manager host start event
  input  wire        host_chg_evt_in,    // Buffer manager host change event
  // Configuration
  input  wire        latch_owner_in,     // 0: network owns latch, 1: host
  input  wire        wr_ack_en_in,       // Host acknowledges by write
  // Network port
  input  wire [15:0] net_addr_in,
  input  wire        net_rd_in,
  input  wire        net_wr_in,
  input  wire [7:0]  net_wdata_in,
  output reg  [7:0]  net_rdata_out,
  // Host port
  input  wire [15:0] host_addr_in,
  input  wire        host_rd_in,
  input  wire        host_wr_in,
  input  wire [7:0]  host_wdata_in,
  output reg  [7:0]  host_rdata_out
);

  // Capture and status storage
  reg  [63:0] rise_time_reg;        // Rising-edge capture
  reg  [63:0] fall_time_reg;        // Falling-edge capture
  reg  [31:0] net_chg_reg;          // Network buffer change time
  reg  [31:0] host_start_reg;       // Host buffer start time
  reg  [31:0] host_chg_reg;         // Host buffer change time
  reg  [31:0] frame_time_reg;       // Local time at current frame start
  reg  [1:0]  mode_reg;             // Single-event mode per edge
  reg  [1:0]  flag_reg;             // Event flags
  reg  [1:0]  armed_reg;            // Single-event capture still allowed
  reg         latch_d_reg;          // Previous latch level
  reg         edge_ok_reg;          // Latch history valid since reset
  reg  [1:0]  flag_next;
  reg  [1:0]  armed_next;
  // Per-port snapshots of the capture registers
  reg  [63:0] net_snap_rise_reg;
  reg  [63:0] net_snap_fall_reg;
  reg  [31:0] net_snap_chg_reg;
  reg  [63:0] host_snap_rise_reg;
  reg  [63:0] host_snap_fall_reg;
  reg  [31:0] host_snap_start_reg;
  reg  [31:0] host_snap_chg_reg;
  reg  [31:0] host_snap_nchg_reg;

  // Edge detection on latch input; held off for the first cycle after
  // reset so a pin already high during reset gives no false rising edge
  wire rise_w = edge_ok_reg & latch_b_in & ~latch_d_reg;
  wire fall_w = edge_ok_reg & ~latch_b_in & latch_d_reg;

  // True when addr lies inside a region of given base and byte count
  function in_region;
    input [15:0] addr;
    input [15:0] base;
    input [15:0] len;
    begin
      in_region = (addr >= base) && (addr < base + len);
    end
  endfunction

  // Select one byte of a 64-bit word by low address bits
  function [7:0] byte_of;
    input [63:0] word;
    input [2:0]  idx;
    begin
      byte_of = word[idx*8 +: 8];
    end
  endfunction

  // Decoded accesses
  wire net_rise_lo  = net_rd_in  && net_addr_in  == `DCLT_RISE_TIME_ADDR;
  wire net_fall_lo  = net_rd_in  && net_addr_in  == `DCLT_FALL_TIME_ADDR;
  wire net_chg_lo   = net_rd_in  && net_addr_in  == `DCLT_NET_CHG_ADDR;
  wire host_rise_rd = host_rd_in && host_addr_in == `DCLT_RISE_TIME_ADDR;
  wire host_fall_rd = host_rd_in && host_addr_in == `DCLT_FALL_TIME_ADDR;
  wire host_rise_wr = host_wr_in && in_region(host_addr_in, `DCLT_RISE_TIME_ADDR, 16'h0008);
  wire host_fall_wr = host_wr_in && in_region(host_addr_in, `DCLT_FALL_TIME_ADDR, 16'h0008);
  wire net_rise_rd  = net_rd_in  && in_region(net_addr_in, `DCLT_RISE_TIME_ADDR, 16'h0008);
  wire net_fall_rd  = net_rd_in  && in_region(net_addr_in, `DCLT_FALL_TIME_ADDR, 16'h0008);
  wire host_rise_rd_any = host_rd_in && in_region(host_addr_in, `DCLT_RISE_TIME_ADDR, 16'h0008);
  wire host_fall_rd_any = host_rd_in && in_region(host_addr_in, `DCLT_FALL_TIME_ADDR, 16'h0008);

  // Acknowledge conditions per flag
  wire ack_rise = (~latch_owner_in & net_rise_rd) |
                  (latch_owner_in & ~wr_ack_en_in & host_rise_rd_any) |
                  (latch_owner_in & wr_ack_en_in & host_rise_wr);
  wire ack_fall = (~latch_owner_in & net_fall_rd) |
                  (latch_owner_in & ~wr_ack_en_in & host_fall_rd_any) |
                  (latch_owner_in & wr_ack_en_in & host_fall_wr);

  // Flag and arm next state; a new event wins over a clear
  always @* begin
    flag_next  = flag_reg;
    armed_next = armed_reg;
    // latch owner's read (host read only without wr_ack_en_in), or host write when wr_ack_en_in, clears rise flag
    if (ack_rise) begin
      flag_next[`DCLT_RISE_BIT]  = 1'b0;
      armed_next[`DCLT_RISE_BIT] = 1'b1;
    end
    if (ack_fall) begin
      flag_next[`DCLT_FALL_BIT]  = 1'b0;
      armed_next[`DCLT_FALL_BIT] = 1'b1;
    end
    if (rise_w && mode_reg[`DCLT_RISE_BIT] && armed_reg[`DCLT_RISE_BIT]) begin
      flag_next[`DCLT_RISE_BIT]  = 1'b1;
      armed_next[`DCLT_RISE_BIT] = 1'b0;
    end
    if (fall_w && mode_reg[`DCLT_FALL_BIT] && armed_reg[`DCLT_FALL_BIT]) begin
      flag_next[`DCLT_FALL_BIT]  = 1'b1;
      armed_next[`DCLT_FALL_BIT] = 1'b0;
    end
    // Continuous mode keeps flags at zero
    if (!mode_reg[`DCLT_RISE_BIT]) begin
      flag_next[`DCLT_RISE_BIT]  = 1'b0;
      armed_next[`DCLT_RISE_BIT] = 1'b1;
    end
    if (!mode_reg[`DCLT_FALL_BIT]) begin
      flag_next[`DCLT_FALL_BIT]  = 1'b0;
      armed_next[`DCLT_FALL_BIT] = 1'b1;
    end
  end

  // Capture, control and flags
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rise_time_reg  <= `DCLT_TIME64_RST;
      fall_time_reg  <= `DCLT_TIME64_RST;
      net_chg_reg    <= `DCLT_TIME32_RST;
      host_start_reg <= `DCLT_TIME32_RST;
      host_chg_reg   <= `DCLT_TIME32_RST;
      frame_time_reg <= `DCLT_TIME32_RST;
      mode_reg       <= 2'h0;
      flag_reg       <= 2'h0;
      armed_reg      <= 2'h3;
      latch_d_reg    <= 1'b0;
      edge_ok_reg    <= 1'b0;
    end else begin
      latch_d_reg <= latch_b_in;
      edge_ok_reg <= 1'b1;
      flag_reg    <= flag_next;
      armed_reg   <= armed_next;
      if (rise_w && (!mode_reg[`DCLT_RISE_BIT] || armed_reg[`DCLT_RISE_BIT])) begin
        rise_time_reg <= sys_time_in;
      end
      if (fall_w && (!mode_reg[`DCLT_FALL_BIT] || armed_reg[`DCLT_FALL_BIT])) begin
        fall_time_reg <= sys_time_in;
      end
      // Remember the local time of each frame start
      if (frame_start_in) begin
        frame_time_reg <= local_time_in;
      end
      if (net_event_in) begin
        net_chg_reg <= frame_start_in ? local_time_in : frame_time_reg;
      end
      if (host_start_evt_in) begin
        host_start_reg <= local_time_in;
      end
      if (host_chg_evt_in) begin
        host_chg_reg <= local_time_in;
      end
      if (net_wr_in && !latch_owner_in && net_addr_in == `DCLT_LATCH_CTRL_ADDR) begin
        mode_reg <= net_wdata_in[1:0];
      end else if (host_wr_in && latch_owner_in &&
                   host_addr_in == `DCLT_LATCH_CTRL_ADDR) begin
        mode_reg <= host_wdata_in[1:0];
      end
    end
  end

  // Snapshots and read data
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      net_snap_rise_reg   <= `DCLT_TIME64_RST;
      net_snap_fall_reg   <= `DCLT_TIME64_RST;
      net_snap_chg_reg    <= `DCLT_TIME32_RST;
      host_snap_rise_reg  <= `DCLT_TIME64_RST;
      host_snap_fall_reg  <= `DCLT_TIME64_RST;
      host_snap_start_reg <= `DCLT_TIME32_RST;
      host_snap_chg_reg   <= `DCLT_TIME32_RST;
      host_snap_nchg_reg  <= `DCLT_TIME32_RST;
      net_rdata_out       <= `DCLT_BYTE_RST;
      host_rdata_out      <= `DCLT_BYTE_RST;
    end else begin
      if (net_rise_lo) net_snap_rise_reg <= rise_time_reg;
      if (net_fall_lo) net_snap_fall_reg <= fall_time_reg;
      if (net_chg_lo)  net_snap_chg_reg  <= net_chg_reg;
      if (host_rise_rd) host_snap_rise_reg <= rise_time_reg;
      if (host_fall_rd) host_snap_fall_reg <= fall_time_reg;
      if (host_rd_in && host_addr_in == `DCLT_HOST_START_ADDR)
        host_snap_start_reg <= host_start_reg;
      if (host_rd_in && host_addr_in == `DCLT_HOST_CHG_ADDR)
        host_snap_chg_reg <= host_chg_reg;
      if (host_rd_in && host_addr_in == `DCLT_NET_CHG_ADDR)
        host_snap_nchg_reg <= net_chg_reg;
      // Network read mux; low byte comes live, upper from snapshot
      if (net_rd_in) begin
        if (net_rise_lo) net_rdata_out <= rise_time_reg[7:0];
        else if (net_fall_lo) net_rdata_out <= fall_time_reg[7:0];
        else if (net_chg_lo) net_rdata_out <= net_chg_reg[7:0];
        else if (net_rise_rd)
          net_rdata_out <= byte_of(net_snap_rise_reg, net_addr_in[2:0]);
        else if (net_fall_rd)
          net_rdata_out <= byte_of(net_snap_fall_reg, net_addr_in[2:0]);
        else if (in_region(net_addr_in, `DCLT_NET_CHG_ADDR, 16'h0004))
          net_rdata_out <= byte_of({32'h0, net_snap_chg_reg}, {1'b0, net_addr_in[1:0]});
        else if (net_addr_in == `DCLT_LATCH_CTRL_ADDR)
          net_rdata_out <= {6'h00, mode_reg};
        else if (net_addr_in == `DCLT_LATCH_STAT_ADDR)
          net_rdata_out <= {5'h00, latch_d_reg, flag_reg};
        else net_rdata_out <= 8'h00;
      end
      // Host read mux
      if (host_rd_in) begin
        if (host_rise_rd) host_rdata_out <= rise_time_reg[7:0];
        else if (host_fall_rd) host_rdata_out <= fall_time_reg[7:0];
        else if (host_addr_in == `DCLT_HOST_START_ADDR) host_rdata_out <= host_start_reg[7:0];
        else if (host_addr_in == `DCLT_HOST_CHG_ADDR) host_rdata_out <= host_chg_reg[7:0];
        else if (host_addr_in == `DCLT_NET_CHG_ADDR) host_rdata_out <= net_chg_reg[7:0];
        else if (host_rise_rd_any)
          host_rdata_out <= byte_of(host_snap_rise_reg, host_addr_in[2:0]);
        else if (host_fall_rd_any)
          host_rdata_out <= byte_of(host_snap_fall_reg, host_addr_in[2:0]);
        else if (in_region(host_addr_in, `DCLT_HOST_START_ADDR, 16'h0004))
          host_rdata_out <= byte_of({32'h0, host_snap_start_reg}, {1'b0, host_addr_in[1:0]});
        else if (in_region(host_addr_in, `DCLT_HOST_CHG_ADDR, 16'h0004))
          host_rdata_out <= byte_of({32'h0, host_snap_chg_reg}, {1'b0, host_addr_in[1:0]});
        else if (in_region(host_addr_in, `DCLT_NET_CHG_ADDR, 16'h0004))
          host_rdata_out <= byte_of({32'h0, host_snap_nchg_reg}, {1'b0, host_addr_in[1:0]});
        else if (host_addr_in == `DCLT_LATCH_CTRL_ADDR)
          host_rdata_out <= {6'h00, mode_reg};
        else if (host_addr_in == `DCLT_LATCH_STAT_ADDR)
          host_rdata_out <= {5'h00, latch_d_reg, flag_reg};
        else host_rdata_out <= 8'h00;
      end
    end
  end

endmodule // dclt_capture

// >>> rtl/dclt_regs.vh
/*
  Register offsets, field positions and reset values for the latch and
  event time-stamp capture block.
  Assumes byte-wide register ports on both the network and host sides.
*/
`ifndef DCLT_REGS_VH
`define DCLT_REGS_VH

// Byte addresses of capture registers (first byte of each)
`define DCLT_RISE_TIME_ADDR    16'h09C0
`define DCLT_FALL_TIME_ADDR    16'h09C8
`define DCLT_NET_CHG_ADDR      16'h09F0
`define DCLT_HOST_START_ADDR   16'h09F8
`define DCLT_HOST_CHG_ADDR     16'h09FC
// Latch control and status byte addresses
`define DCLT_LATCH_CTRL_ADDR   16'h09A9
`define DCLT_LATCH_STAT_ADDR   16'h09AF
// Field positions
`define DCLT_RISE_BIT          0
`define DCLT_FALL_BIT          1
`define DCLT_PIN_BIT           2
// Reset values
`define DCLT_TIME64_RST        64'h0000000000000000
`define DCLT_TIME32_RST        32'h00000000
`define DCLT_BYTE_RST          8'h00

`endif

// >>> sim/dclt_capture_chk.sv
/* Checker on the byte ports of the latch and event time-stamp block.
   Assumes it is bound into the block from the bench top file. */
`include "dclt_regs.vh"
module dclt_capture_chk (
  // Clock, reset and levels
  input wire logic        clk_sys_in, rst_in, latch_b_in, latch_owner_in, wr_ack_en_in,
  // Strobes and addresses
  input wire logic        net_rd_in, host_rd_in, host_wr_in,
  input wire logic [15:0] net_addr_in, host_addr_in,
  // Read data
  input wire logic [7:0]  net_rdata_out, host_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Reset must clear both read buses
  rst_zero_a: assert property (disable iff (1'b0)
    rst_in |=> net_rdata_out == 8'h00 && host_rdata_out == 8'h00) else $error("rdata not reset");
  net_hold_a: assert property (
    !net_rd_in |=> $stable(net_rdata_out)) else $error("net rdata moved");
  host_hold_a: assert property (
    !host_rd_in |=> $stable(host_rdata_out)) else $error("host rdata moved");
  net_unmap_a: assert property (
    net_rd_in && net_addr_in == 16'h0100 |=> net_rdata_out == 8'h00) else $error("net unmapped");
  host_unmap_a: assert property (
    host_rd_in && host_addr_in == 16'h0E00 |=> host_rdata_out == 8'h00) else $error("host unmap");
  pin_state_a: assert property (
    net_rd_in && net_addr_in == `DCLT_LATCH_STAT_ADDR && $stable(latch_b_in)
    |=> net_rdata_out[2] == ($past(latch_b_in) && !$past(rst_in, 2)))
    else $error("pin state wrong");
  stat_rsvd_a: assert property (
    net_rd_in && net_addr_in == `DCLT_LATCH_STAT_ADDR |=> net_rdata_out[7:3] == 5'h00)
    else $error("status reserved set");
  ctrl_rsvd_a: assert property (
    host_rd_in && host_addr_in == `DCLT_LATCH_CTRL_ADDR |=> host_rdata_out[7:2] == 6'h00)
    else $error("control reserved set");
  // Main scenarios reached
  cover property (net_rd_in && net_addr_in == `DCLT_RISE_TIME_ADDR);
  cover property (host_wr_in && latch_owner_in && wr_ack_en_in);
  cover property ($rose(latch_b_in));
endmodule // dclt_capture_chk

// >>> sim/dclt_capture_tb.sv
/* Self-checking bench for the latch and event time-stamp block.
   Assumes the block answers reads one cycle after the strobe. */
`include "dclt_regs.vh"
module dclt_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit h; logic [15:0] a; int n; logic [63:0] e;} dclt_row_t;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1, latch_b_in = 1'b0, run = 1'b1;
  logic        latch_owner_in = 1'b0, wr_ack_en_in = 1'b0;
  logic        net_rd_in = 1'b0, net_wr_in = 1'b0, host_rd_in = 1'b0, host_wr_in = 1'b0;
  logic [3:0]  evt = 4'h0;
  logic [15:0] net_addr_in = 16'h0000, host_addr_in = 16'h0000;
  logic [7:0]  net_wdata_in = 8'h00, host_wdata_in = 8'h00, net_rdata_out, host_rdata_out;
  logic [63:0] sys_time, v, w, t1, t2;
  logic [31:0] local_time, l1, l2, l3;
  int          errors = 0, checks = 0;
  // Reset values: host side, address, bytes, expected
  dclt_row_t rows [9] = '{'{0, `DCLT_RISE_TIME_ADDR, 8, 64'h0}, '{1, `DCLT_FALL_TIME_ADDR, 8, 64'h0},
    '{0, `DCLT_NET_CHG_ADDR, 4, 64'h0}, '{1, `DCLT_HOST_START_ADDR, 4, 64'h0},
    '{1, `DCLT_HOST_CHG_ADDR, 4, 64'h0}, '{0, `DCLT_LATCH_STAT_ADDR, 1, 64'h0},
    '{1, `DCLT_LATCH_CTRL_ADDR, 1, 64'h0}, '{0, 16'h0100, 1, 64'h0}, '{1, 16'h0E00, 1, 64'h0}};
  always #2.5 clk_sys_in = ~clk_sys_in;
  dclt_time_src u_time (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .run_in(run),
    .sys_time_out(sys_time), .local_time_out(local_time));
  dclt_capture DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sys_time_in(sys_time),
    .local_time_in(local_time), .latch_b_in(latch_b_in), .frame_start_in(evt[0]),
    .net_event_in(evt[1]), .host_start_evt_in(evt[2]), .host_chg_evt_in(evt[3]),
    .latch_owner_in(latch_owner_in), .wr_ack_en_in(wr_ack_en_in), .net_addr_in(net_addr_in),
    .net_rd_in(net_rd_in), .net_wr_in(net_wr_in), .net_wdata_in(net_wdata_in),
    .net_rdata_out(net_rdata_out), .host_addr_in(host_addr_in), .host_rd_in(host_rd_in),
    .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out));
  // Compare and count
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Back-to-back byte reads on one port, low byte first
  task automatic rd(input bit h, input logic [15:0] a, input int n, output logic [63:0] d);
    d = 64'h0;
    @(posedge clk_sys_in);
    {net_addr_in, host_addr_in, host_rd_in, net_rd_in} <= {a, a, h, !h};
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_in);
      {net_addr_in, host_addr_in} <= {a + 16'(i + 1), a + 16'(i + 1)};
      if (i == n - 1) {host_rd_in, net_rd_in} <= 2'b00;
      #1 d[i*8 +: 8] = h ? host_rdata_out : net_rdata_out;
    end
  endtask
  // One-cycle byte write on one port
  task automatic wr(input bit h, input logic [15:0] a, input logic [7:0] b);
    @(posedge clk_sys_in);
    {net_addr_in, host_addr_in, net_wdata_in, host_wdata_in} <= {a, a, b, b};
    {host_wr_in, net_wr_in} <= {h, !h};
    @(posedge clk_sys_in);
    {host_wr_in, net_wr_in} <= 2'b00;
  endtask
  // Latch level change with time frozen; returns the time due
  task automatic lat(input logic l, output logic [63:0] t);
    @(posedge clk_sys_in);
    run <= 1'b0;
    @(posedge clk_sys_in);
    latch_b_in <= l;
    repeat (3) @(posedge clk_sys_in);
    t = sys_time;
    run <= 1'b1;
  endtask
  // One-cycle event pulse; returns local time of that cycle
  task automatic pulse(input int k, output logic [31:0] t);
    @(posedge clk_sys_in);
    evt[k] <= 1'b1;
    #1 t = local_time;
    @(posedge clk_sys_in);
    evt[k] <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].h, rows[i].a, rows[i].n, v);
      chk(v, rows[i].e);
    end
    $display("done reset values");
    lat(1'b1, t1);
    rd(0, `DCLT_RISE_TIME_ADDR, 1, v);
    lat(1'b0, t2);
    lat(1'b1, w);
    rd(0, `DCLT_RISE_TIME_ADDR + 16'h1, 7, v);
    chk({v[55:0], 8'h00} | (t1 & 64'hFF), t1);
    rd(1, `DCLT_RISE_TIME_ADDR, 8, v);
    chk(v, w);
    rd(1, `DCLT_FALL_TIME_ADDR, 8, v);
    chk(v, t2);
    rd(0, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h04);
    $display("done continuous capture");
    wr(0, `DCLT_LATCH_CTRL_ADDR, 8'h03);
    lat(1'b0, t2);
    lat(1'b1, t1);
    lat(1'b0, v);
    lat(1'b1, v);
    rd(0, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h07);
    wr(0, `DCLT_RISE_TIME_ADDR, 8'hFF);
    rd(0, `DCLT_RISE_TIME_ADDR, 8, v);
    chk(v, t1);
    rd(0, `DCLT_FALL_TIME_ADDR, 8, v);
    chk(v, t2);
    rd(0, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h04);
    $display("done single event");
    @(posedge clk_sys_in);
    latch_owner_in <= 1'b1;
    lat(1'b0, t2);
    wr(1, `DCLT_FALL_TIME_ADDR, 8'h00);
    rd(1, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h02);
    rd(1, `DCLT_FALL_TIME_ADDR, 8, v);
    chk(v, t2);
    rd(1, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h00);
    @(posedge clk_sys_in);
    wr_ack_en_in <= 1'b1;
    lat(1'b1, t1);
    wr(1, `DCLT_RISE_TIME_ADDR, 8'h00);
    rd(1, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h04);
    $display("done host acknowledge");
    pulse(0, l1);
    repeat (4) @(posedge clk_sys_in);
    pulse(1, l2);
    rd(0, `DCLT_NET_CHG_ADDR, 1, w);
    pulse(0, l2);
    pulse(1, l3);
    rd(0, `DCLT_NET_CHG_ADDR + 16'h1, 3, v);
    chk({32'h0, v[23:0], w[7:0]}, 64'(l1));
    pulse(2, l2);
    pulse(3, l3);
    rd(1, `DCLT_HOST_START_ADDR, 4, v);
    chk(v, 64'(l2));
    rd(1, `DCLT_HOST_CHG_ADDR, 4, v);
    chk(v, 64'(l3));
    rd(1, `DCLT_HOST_START_ADDR, 1, w);
    pulse(2, l1);
    rd(1, `DCLT_HOST_START_ADDR + 16'h1, 3, v);
    chk({32'h0, v[23:0], w[7:0]}, 64'(l2));
    $display("done event times");
    // Mid-run reset with the latch pin high: rise time, flags and mode cleared, no false edge
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(1, `DCLT_RISE_TIME_ADDR, 8, v);
    chk(v, 64'h0);
    rd(0, `DCLT_LATCH_STAT_ADDR, 1, v);
    chk(v, 64'h04);
    rd(1, `DCLT_LATCH_CTRL_ADDR, 1, v);
    chk(v, 64'h0);
    $display("done mid-run reset");
    end_sim;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    errors++;
    end_sim;
  end
endmodule // dclt_capture_tb
bind dclt_capture dclt_capture_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .latch_b_in(latch_b_in), .latch_owner_in(latch_owner_in), .wr_ack_en_in(wr_ack_en_in),
  .net_rd_in(net_rd_in), .host_rd_in(host_rd_in), .host_wr_in(host_wr_in),
  .net_addr_in(net_addr_in), .host_addr_in(host_addr_in),
  .net_rdata_out(net_rdata_out), .host_rdata_out(host_rdata_out));

// >>> sim/dclt_time_src.sv
/* Time-base source beside the block: system and local time counters.
   Assumes the bench freezes it around each latch edge so the captured time is known. */
module dclt_time_src (
  // Clock, reset and run control
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  // Time bases
  output logic      [63:0] sys_time_out,
  output logic      [31:0] local_time_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Step touches every byte so a stale upper byte shows up
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      sys_time_out   <= 64'h0123456789ABCDEF;
      local_time_out <= 32'h89ABCDEF;
    end else if (run_in) begin
      sys_time_out   <= sys_time_out + 64'h0101010101010101;
      local_time_out <= local_time_out + 32'h01010101;
    end
  end
endmodule // dclt_time_src
